// [core/cxo_ctrl.sv]
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module cxo_ctrl
    import cxo_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC
)(
    input  wire logic              clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Clock generator side
    input  wire logic              osc_run_request,
    input  wire logic              internal_osc_select,
    input  wire logic              stop_mode,
    input  wire logic              vlls_wake,
    // Crystal pins
    input  wire logic              clock_input_pin,
    output logic                   osc_drive_pin,
    output logic                   osc_drive_oe_n,
    // Clock outputs and status
    output logic                   module_out_clock,
    output logic                   peripheral_ref_clock,
    output logic                   raw_osc_clock,
    output logic                   startup_count_done,
    output logic      [3:0]        load_cap_sel,
    output logic      [CAP_W-1:0]  load_cap_pf,
    output cxo_fsm_t               osc_state
);

    ////////////////////////////////////////////////////////////////////
    // Declarations

    cxo_state_t st_r;
    cxo_state_t st_nxt;

    logic       raw_s;
    logic       raw_rise;
    logic       reg_hit;
    logic       ref_en;
    logic       stop_keep;
    logic       stop_rise;
    logic       stop_ok_now;
    logic       osc_en;
    logic       int_en;
    logic       cnt_clear;
    logic       cnt_tick;
    logic       cnt_done;

    ////////////////////////////////////////////////////////////////////
    // Pin synchroniser and start-up counter

    // Clock input pin enters through two flops
    cxo_sync u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .pin_in   (clock_input_pin),
        .pin_sync (raw_s)
    );

    // Start-up cycle counter
    cxo_startup_cnt #(
        .CYCLES (STARTUP_CYCLES)
    ) u_cnt (
        .clk   (clk),
        .nrst  (nrst),
        .clear (cnt_clear),
        .tick  (cnt_tick),
        .done  (cnt_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Enable decode

    // Control fields and address match
    assign reg_hit   = reg_addr == OSC_CTRL_OFF;
    assign ref_en    = st_r.ctrl[REF_EN_BIT];
    assign stop_keep = st_r.ctrl[STOP_KEEP_BIT];

    // Stop entry edge; enable state at entry is latched in stop_ok
    assign stop_rise = stop_mode && !st_r.stop_d;
    assign stop_ok_now = ref_en && stop_keep
                         && (stop_rise || st_r.stop_ok);

    assign osc_en = stop_mode ? stop_ok_now : osc_run_request;

    // Internal oscillator path wanted
    assign int_en = osc_en && internal_osc_select;

    assign cnt_clear = !int_en;

    // Rising edge of the synchronised raw clock
    assign raw_rise = raw_s && !st_r.raw_d;

    assign cnt_tick = raw_rise && (st_r.fsm == CXO_STARTUP);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        st_nxt        = st_r;
        st_nxt.raw_d  = raw_s;
        st_nxt.stop_d = stop_mode;
        st_nxt.stop_ok = stop_mode && stop_ok_now;

        if (vlls_wake) begin
            st_nxt.ctrl = OSC_CTRL_RST;
        end else if (reg_wr && reg_hit) begin
            st_nxt.ctrl = reg_wdata & OSC_CTRL_WMSK;
        end

        if (reg_rd && reg_hit) begin
            st_nxt.rdata = st_r.ctrl;
        end else begin
            st_nxt.rdata = 8'h00;
        end

        st_nxt.cap_pf =
            (st_nxt.ctrl[CAP_TWO_BIT]   ? CAP_PF_TWO   : 5'h00)
          + (st_nxt.ctrl[CAP_FOUR_BIT]  ? CAP_PF_FOUR  : 5'h00)
          + (st_nxt.ctrl[CAP_EIGHT_BIT] ? CAP_PF_EIGHT : 5'h00)
          + (st_nxt.ctrl[CAP_SIXT_BIT]  ? CAP_PF_SIXT  : 5'h00);

        // State sequence
        case (st_r.fsm)
            CXO_OFF: begin
                if (int_en) begin
                    st_nxt.fsm = CXO_STARTUP;
                end else if (osc_en) begin
                    st_nxt.fsm = CXO_EXTCLK;
                end
            end
            CXO_STARTUP: begin
                if (!osc_en) begin
                    st_nxt.fsm = CXO_OFF;
                end else if (!internal_osc_select) begin
                    st_nxt.fsm = CXO_EXTCLK;
                end else if (cnt_done) begin
                    st_nxt.fsm = CXO_STABLE;
                end
            end
            CXO_STABLE: begin
                if (!osc_en) begin
                    st_nxt.fsm = CXO_OFF;
                end else if (!internal_osc_select) begin
                    st_nxt.fsm = CXO_EXTCLK;
                end
            end
            CXO_EXTCLK: begin
                if (!osc_en) begin
                    st_nxt.fsm = CXO_OFF;
                end else if (internal_osc_select) begin
                    st_nxt.fsm = CXO_STARTUP;
                end
            end
            default: begin
                st_nxt.fsm = CXO_OFF;
            end
        endcase

        case (st_r.fsm)
            CXO_STARTUP: begin
                st_nxt.raw_out    = raw_s;
                st_nxt.clk_out    = 1'b0;
                st_nxt.drive      = !raw_s;
                st_nxt.drive_oe_n = 1'b0;
            end
            CXO_STABLE: begin
                st_nxt.raw_out    = raw_s;
                st_nxt.clk_out    = raw_s;
                st_nxt.drive      = !raw_s;
                st_nxt.drive_oe_n = 1'b0;
            end
            CXO_EXTCLK: begin
                st_nxt.raw_out    = raw_s;
                st_nxt.clk_out    = raw_s;
                st_nxt.drive      = 1'b0;
                st_nxt.drive_oe_n = 1'b1;
            end
            default: begin
                st_nxt.raw_out    = 1'b0;
                st_nxt.clk_out    = 1'b0;
                st_nxt.drive      = 1'b0;
                st_nxt.drive_oe_n = 1'b1;
            end
        endcase

        st_nxt.ref_out = ref_en && st_nxt.clk_out
                         && (!stop_mode || stop_ok_now);
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= CXO_ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    // Everything except startup_count_done comes straight from the state register
    assign reg_rdata            = st_r.rdata;
    assign osc_drive_pin        = st_r.drive;
    assign osc_drive_oe_n       = st_r.drive_oe_n;
    assign module_out_clock     = st_r.clk_out;
    assign peripheral_ref_clock = st_r.ref_out;
    assign raw_osc_clock        = st_r.raw_out;
    assign startup_count_done   = cnt_done;
    assign load_cap_sel         = st_r.ctrl[3:0];
    assign load_cap_pf          = st_r.cap_pf;
    assign osc_state            = st_r.fsm;

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_read_ctrl_val: assert property (
        @(posedge clk) disable iff (!nrst)
        reg_rd && reg_hit && !vlls_wake
        |=> reg_rdata == $past(st_r.ctrl) ##1 reg_rdata == 8'h00
            || $past(reg_rd, 1))
        else $error("read data wrong or not one cycle");

    a_rsv_read_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        reg_wr && reg_hit && !vlls_wake
        |=> st_r.ctrl[RSV_HI_BIT] == 1'b0
            && st_r.ctrl[RSV_LO_BIT] == 1'b0
            && st_r.ctrl[REF_EN_BIT] == $past(reg_wdata[REF_EN_BIT]))
        else $error("reserved bit stored or write lost");

    a_ref_disabled: assert property (
        @(posedge clk) disable iff (!nrst)
        !ref_en |=> !peripheral_ref_clock)
        else $error("reference clock active while disabled");

    a_stop_ref_off: assert property (
        @(posedge clk) disable iff (!nrst)
        stop_mode && !stop_keep |=> !peripheral_ref_clock)
        else $error("reference clock runs in stop without keep bit");

    a_stop_osc_off: assert property (
        @(posedge clk) disable iff (!nrst)
        stop_mode && !(ref_en && stop_keep) [*2]
        |=> osc_state == CXO_OFF)
        else $error("oscillator runs in stop without both bits");

    a_cap_weight: assert property (
        @(posedge clk) disable iff (!nrst)
        load_cap_pf == {st_r.ctrl[0], st_r.ctrl[1],
                        st_r.ctrl[2], st_r.ctrl[3], 1'b0})
        else $error("load capacitance sum wrong");

    a_off_static: assert property (
        @(posedge clk) disable iff (!nrst)
        osc_state == CXO_OFF
        |=> !raw_osc_clock && osc_drive_oe_n && !module_out_clock)
        else $error("off state not static or pins coupled");

    a_start_gated: assert property (
        @(posedge clk) disable iff (!nrst)
        osc_state == CXO_OFF && int_en
        |=> osc_state == CXO_STARTUP ##1 !module_out_clock)
        else $error("start-up not entered or output not gated");

    a_stable_entry: assert property (
        @(posedge clk) disable iff (!nrst)
        osc_state == CXO_STARTUP && cnt_done && int_en
        |=> osc_state == CXO_STABLE)
        else $error("stable state not entered after count");

    a_ext_passes: assert property (
        @(posedge clk) disable iff (!nrst)
        osc_state == CXO_EXTCLK
        |=> module_out_clock == $past(raw_s) && osc_drive_oe_n)
        else $error("external clock not passed through");

    a_wake_reset: assert property (
        @(posedge clk) disable iff (!nrst)
        vlls_wake |=> st_r.ctrl == OSC_CTRL_RST)
        else $error("control not reset on deep stop wake");

    a_start_out_low: assert property (
        @(posedge clk) disable iff (!nrst)
        osc_state == CXO_STARTUP |=> !module_out_clock)
        else $error("output clock not gated during start-up");

    a_amp_drives: assert property (
        @(posedge clk) disable iff (!nrst)
        osc_state == CXO_STARTUP || osc_state == CXO_STABLE
        |=> !osc_drive_oe_n && osc_drive_pin == !$past(raw_s))
        else $error("amplifier not driving the drive pin");

    a_stable_follow: assert property (
        @(posedge clk) disable iff (!nrst)
        osc_state == CXO_STABLE |=> module_out_clock == $past(raw_s))
        else $error("stable output does not follow raw clock");

    a_ref_follow: assert property (
        @(posedge clk) disable iff (!nrst)
        ref_en && !stop_mode
        |=> peripheral_ref_clock == module_out_clock)
        else $error("reference clock does not follow output");

endmodule : cxo_ctrl

// [core/cxo_pkg.sv]
package cxo_pkg;

    ////////////////////////////////////////////////////////////////////
    // Register bus geometry
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam logic [7:0]  OSC_CTRL_OFF  = 8'h00;

    ////////////////////////////////////////////////////////////////////
    // Control register layout
    localparam logic [7:0]  OSC_CTRL_RST  = 8'h00;
    localparam int          REF_EN_BIT    = 7;
    localparam int          RSV_HI_BIT    = 6;
    localparam int          STOP_KEEP_BIT = 5;
    localparam int          RSV_LO_BIT    = 4;
    localparam int          CAP_TWO_BIT   = 3;
    localparam int          CAP_FOUR_BIT  = 2;
    localparam int          CAP_EIGHT_BIT = 1;
    localparam int          CAP_SIXT_BIT  = 0;
    // Writable bits: reserved bits 6 and 4 are masked out
    localparam logic [7:0]  OSC_CTRL_WMSK = 8'haf;

    ////////////////////////////////////////////////////////////////////
    // Load capacitor weights in pF
    localparam int          CAP_W         = 5;
    localparam logic [4:0]  CAP_PF_TWO    = 5'h02;
    localparam logic [4:0]  CAP_PF_FOUR   = 5'h04;
    localparam logic [4:0]  CAP_PF_EIGHT  = 5'h08;
    localparam logic [4:0]  CAP_PF_SIXT   = 5'h10;

    ////////////////////////////////////////////////////////////////////
    // Start-up counter: raw oscillator cycles before release
    localparam int          CNT_W         = 13;
    localparam int          STARTUP_CYC   = 4096;

    ////////////////////////////////////////////////////////////////////
    // Oscillator states
    typedef enum logic [1:0] {
        CXO_OFF,
        CXO_STARTUP,
        CXO_STABLE,
        CXO_EXTCLK
    } cxo_fsm_t;

    // Two-stage pin synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
    } cxo_sync_t;

    // Start-up counter state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             done;
    } cxo_cnt_t;

    // Control block state
    typedef struct packed {
        logic [7:0]       ctrl;
        cxo_fsm_t         fsm;
        logic [7:0]       rdata;
        logic             clk_out;
        logic             ref_out;
        logic             raw_out;
        logic             drive;
        logic             drive_oe_n;
        logic [CAP_W-1:0] cap_pf;
        logic             raw_d;
        logic             stop_d;
        logic             stop_ok;
    } cxo_state_t;

    localparam cxo_state_t CXO_ST_RST = '{
        ctrl:       OSC_CTRL_RST,
        fsm:        CXO_OFF,
        rdata:      8'h00,
        clk_out:    1'b0,
        ref_out:    1'b0,
        raw_out:    1'b0,
        drive:      1'b0,
        drive_oe_n: 1'b1,
        cap_pf:     5'h00,
        raw_d:      1'b0,
        stop_d:     1'b0,
        stop_ok:    1'b0
    };

endpackage : cxo_pkg

// [core/cxo_sync.sv]
`timescale 1ns/10ps
// Two flip-flop synchroniser for the clock input pin
module cxo_sync
    import cxo_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin_in,
    output logic      pin_sync
);

    cxo_sync_t st_r;
    cxo_sync_t st_nxt;

    // First stage feeds only the second stage
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_sync = st_r.s2;

endmodule : cxo_sync

// [core/cxo_startup_cnt.sv]
`timescale 1ns/10ps
// Saturating counter of raw oscillator cycles during start-up
module cxo_startup_cnt
    import cxo_pkg::*;
#(
    parameter int CYCLES = STARTUP_CYC
)(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic clear,
    input  wire logic tick,
    output logic      done
);

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(CYCLES);

    cxo_cnt_t st_r;
    cxo_cnt_t st_nxt;

    // Count ticks, stop at the limit, restart on clear
    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            st_nxt = '0;
        end else if (st_r.cnt == LIMIT) begin
            st_nxt.done = 1'b1;
        end else if (tick) begin
            st_nxt.cnt  = st_r.cnt + CNT_W'(1);
            st_nxt.done = (st_r.cnt + CNT_W'(1)) == LIMIT;
        end
    end

    // State register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;

    a_cnt_clear: assert property (
        @(posedge clk) disable iff (!nrst)
        clear |=> !done && st_r.cnt == '0)
        else $error("start-up counter not cleared");

    a_cnt_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        done && !clear |=> done)
        else $error("count done dropped without clear");

endmodule : cxo_startup_cnt

// [bench/cxo_osc_drive_pin_model.sv]
`timescale 1ns/10ps
// Crystal or bypass clock source seen from the clock input pin
module cxo_osc_drive_pin_model #(
    parameter int HALF_NS = 40
)(
    input  wire logic osc_drive_oe_n,
    input  wire logic ext_drive,
    output logic      clock_input_pin
);
    logic run;

    // Resonator swings only while the amplifier drives it or a source feeds it
    assign run = (osc_drive_oe_n === 1'b0) || (ext_drive === 1'b1);

    // Without excitation the resonator dies out and the pin sits at bias
    initial begin
        clock_input_pin = 1'b0;
        forever begin
            #HALF_NS;
            clock_input_pin = run ? ~clock_input_pin : 1'b0;
        end
    end
endmodule : cxo_osc_drive_pin_model

// [bench/tb.sv]
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb
    import cxo_pkg::*;
;
    typedef struct packed {
        logic [7:0] wd;
        logic [7:0] rd;
        logic [4:0] pf;
    } cxo_row_t;
    localparam int       SIM_CYC = 8;
    localparam cxo_row_t ROWS [8] = '{
        '{8'hff, 8'haf, 5'h1e}, '{8'h50, 8'h00, 5'h00},
        '{8'h08, 8'h08, 5'h02}, '{8'h04, 8'h04, 5'h04},
        '{8'h02, 8'h02, 5'h08}, '{8'h01, 8'h01, 5'h10},
        '{8'ha0, 8'ha0, 5'h00}, '{8'h00, 8'h00, 5'h00}};
    logic       clk, nrst, reg_wr, reg_rd, run, sel, stop, wake, ext, pin;
    logic       drv, oe_n, mclk, rclk, raw, done;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
    logic [3:0] cap_sel;
    logic [4:0] cap_pf;
    cxo_fsm_t   osc_state;
    int         failures, num_checks, hi, rbad, dbad;

    cxo_ctrl #(.STARTUP_CYCLES(SIM_CYC)) i_cxo_ctrl (
        .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .osc_run_request(run), .internal_osc_select(sel),
        .stop_mode(stop), .vlls_wake(wake), .clock_input_pin(pin),
        .osc_drive_pin(drv), .osc_drive_oe_n(oe_n),
        .module_out_clock(mclk), .peripheral_ref_clock(rclk),
        .raw_osc_clock(raw), .startup_count_done(done),
        .load_cap_sel(cap_sel), .load_cap_pf(cap_pf), .osc_state(osc_state));
    cxo_osc_drive_pin_model i_cxo_osc_drive_pin_model (
        .osc_drive_oe_n(oe_n), .ext_drive(ext), .clock_input_pin(pin));

    ////////////////////////////////////////////////////////////////////
    // Clock and a hang limit
    always #5 clk = ~clk;
    initial begin
        #300000;
        failures++;
        $display("ERROR watchdog expected finish seen hang");
        summarize();
    end

    ////////////////////////////////////////////////////////////////////
    // Verdict and run end
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // One-cycle read strobe, data taken in the following cycle only
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(negedge clk);
        `CHK("rdata_after", 8'h00, reg_rdata)
    endtask : reg_read

    // Bounded wait for a state
    task automatic wait_state(input cxo_fsm_t s, input int n);
        for (int i = 0; i < n && osc_state !== s; i++) @(negedge clk);
        num_checks++;
        if (osc_state !== s) begin
            failures++;
            $display("ERROR osc_state expected %h seen %h", s, osc_state);
            summarize();
        end
    endtask : wait_state

    // Counts output highs and reference mismatches over 40 cycles
    task automatic watch(input logic ref_on);
        hi   = 0;
        rbad = 0;
        dbad = 0;
        // Let a just-changed input reach the registered outputs
        @(negedge clk);
        repeat (40) begin
            @(negedge clk);
            if (mclk === 1'b1) hi++;
            if (rclk !== (ref_on ? mclk : 1'b0)) rbad++;
            if (drv !== (oe_n === 1'b0 ? ~raw : 1'b0)) dbad++;
        end
    endtask : watch

    // Crystal start-up: gated output, full count, then stable
    task automatic start_osc_drive_pin();
        int   rises, bad;
        logic prev;
        rises = 0;
        bad   = 0;
        prev  = pin;
        @(posedge clk);
        sel <= 1'b1;
        run <= 1'b1;
        wait_state(CXO_STARTUP, 3);
        // Pin enable follows the state by one cycle
        @(negedge clk);
        `CHK("drive_oe_n", 1'b0, oe_n)
        for (int i = 0; i < 400 && done !== 1'b1; i++) begin
            @(negedge clk);
            if (pin === 1'b1 && prev === 1'b0) rises++;
            prev = pin;
            if (mclk !== 1'b0) bad++;
        end
        `CHK("count_done", 1'b1, done)
        `CHK("rise_count", 1'b1, rises >= SIM_CYC && rises <= SIM_CYC + 1)
        `CHK("gated_out", 0, bad)
        wait_state(CXO_STABLE, 3);
    endtask : start_osc_drive_pin

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk = 0;
        nrst = 0;
        {reg_wr, reg_rd, run, sel, stop, wake, ext} = '0;
        reg_addr = '0;
        reg_wdata = '0;
        failures = 0;
        num_checks = 0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        `CHK("state_rst", CXO_OFF, osc_state)
        `CHK("oe_n_rst", 1'b1, oe_n)
        `CHK("outs_rst", 4'h0, {mclk, rclk, raw, done})
        reg_read(OSC_CTRL_OFF, rd);
        `CHK("ctrl_rst", OSC_CTRL_RST, rd)
        // Register rows: reserved bits and load capacitor weights
        foreach (ROWS[k]) begin
            reg_write(OSC_CTRL_OFF, ROWS[k].wd);
            reg_read(OSC_CTRL_OFF, rd);
            `CHK("ctrl_rd", ROWS[k].rd, rd)
            `CHK("cap_sel", ROWS[k].rd[3:0], cap_sel)
            `CHK("cap_pf", ROWS[k].pf, cap_pf)
        end
        // Unmapped address: write ignored, read gives zero
        reg_write(8'h05, 8'hff);
        reg_read(8'h05, rd);
        `CHK("unmapped_rd", 8'h00, rd)
        reg_read(OSC_CTRL_OFF, rd);
        `CHK("ctrl_kept", 8'h00, rd)
        // Crystal start with reference and stop-keep enabled
        reg_write(OSC_CTRL_OFF, 8'ha0);
        start_osc_drive_pin();
        watch(1'b1);
        `CHK("out_toggles", 1'b1, hi > 0 && hi < 40)
        `CHK("ref_follows", 0, rbad)
        `CHK("done_held", 1'b1, done)
        `CHK("drive_inv", 0, dbad)
        // Reference clock disabled while running, stop-keep left set
        reg_write(OSC_CTRL_OFF, 8'h20);
        watch(1'b0);
        `CHK("ref_off", 0, rbad)
        // Stop with both bits set keeps the reference running
        reg_write(OSC_CTRL_OFF, 8'ha0);
        stop <= 1'b1;
        watch(1'b1);
        `CHK("stop_keep_st", CXO_STABLE, osc_state)
        `CHK("stop_keep_ref", 1'b1, rbad == 0 && hi > 0)
        @(posedge clk);
        stop <= 1'b0;
        reg_write(OSC_CTRL_OFF, 8'h80);
        stop <= 1'b1;
        wait_state(CXO_OFF, 4);
        watch(1'b0);
        `CHK("stop_ref_off", 0, rbad + hi)
        @(posedge clk);
        stop <= 1'b0;
        // Disable clears the counter, re-enable counts in full
        run <= 1'b0;
        repeat (2) @(negedge clk);
        wait_state(CXO_OFF, 3);
        repeat (3) @(negedge clk);
        `CHK("off_outs", 4'h1, {done, raw, mclk, oe_n})
        start_osc_drive_pin();
        // External clock bypass without the start-up count
        @(posedge clk);
        run <= 1'b0;
        wait_state(CXO_OFF, 3);
        @(posedge clk);
        ext <= 1'b1;
        sel <= 1'b0;
        run <= 1'b1;
        wait_state(CXO_EXTCLK, 3);
        watch(1'b1);
        `CHK("ext_toggles", 1'b1, hi > 0 && hi < 40)
        `CHK("ext_ref", 0, rbad)
        `CHK("ext_drive_off", 0, dbad)
        `CHK("ext_oe_n", 1'b1, oe_n)
        @(posedge clk);
        run <= 1'b0;
        ext <= 1'b0;
        // Deep-stop wake clears the register
        reg_write(OSC_CTRL_OFF, 8'haf);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        reg_read(OSC_CTRL_OFF, rd);
        `CHK("wake_clear", OSC_CTRL_RST, rd)
        // Reset with run low after a register write returns register and state to reset values
        reg_write(OSC_CTRL_OFF, 8'haf);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        `CHK("state_rst2", CXO_OFF, osc_state)
        `CHK("oe_n_rst2", 1'b1, oe_n)
        reg_read(OSC_CTRL_OFF, rd);
        `CHK("ctrl_rst2", OSC_CTRL_RST, rd)
        summarize();
    end
endmodule : tb
